// *** hdl/vrc_ctrl.sv ***
// Mode controller for calibration of the data-input reference level.
//
// ----------------------------------------------------------------
// Rules
// ----------------------------------------------------------------
// Operation
// R1: MR6 bit7 enters, bit6 range, level ignored.
// R2: Host waits entry delay before commands.
// R3: Only ACT/WR/RD/PRE/DES/MRS allowed in mode; code flags MRS to any register other than MR6.
// R4: Dummy writes accepted before first adjustment.
// R5: Level writes keep bit7 set, same range.
// R6: MR6 with bit7 low leaves bits 6:0.
// R7: Host waits settling time after level write.
// R8: Per-device addressing permits only MRS commands.
// R9: Last written range and level used after exit.
// R10: Exit only with all banks precharged.
// R11: Only deselects until calibration exit delay.
// R12: Finish with final level, then exit.
// R13: Range changes only on entry command.
// R14: Entry command carries no new level.
// R15: Settle latest step before disabling mode.
// R16: Bit6 picks range one or two.
// R17: Active flag and latched range during mode.
// R18: Host sweeps codes to find eye center.
module vrc_ctrl
  import vrc_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic               cs_n,
  input  wire logic               act_n,
  input  wire logic               ras_n,
  input  wire logic               cas_n,
  input  wire logic               we_n,
  input  wire logic [1:0]         bg,
  input  wire logic [1:0]         ba,
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic               per_device_addressing,
  input  wire logic               pda_dq0,
  output logic                    cal_active,
  output logic                    ref_range,
  output logic [LVL_W-1:0]        dq_input_reference_level,
  output logic                    ref_valid,
  output logic                    dummy_write_ok,
  output logic                    cmd_illegal
);
  import vrc_pkg::*;

  vrc_cmd_if cmd ();

  vrc_state_t        st_q;
  logic              range_q;
  logic [LVL_W-1:0]  level_q;
  logic [TMR_W-1:0]  phase_tmr_q;
  logic [TMR_W-1:0]  settle_tmr_q;
  logic [15:0]       open_q;
  logic              first_done_q;
  logic              active_q;
  logic              valid_q;
  logic              dummy_q;
  logic              illegal_q;
  logic              mr6_hit;
  logic              lvl_wr;
  logic              exit_cmd;
  logic              bad;
  logic              pda_q;

  vrc_cmd_dec u_dec (
    .core_clk              (core_clk),
    .nrst                  (nrst),
    .cs_n                  (cs_n),
    .act_n                 (act_n),
    .ras_n                 (ras_n),
    .cas_n                 (cas_n),
    .we_n                  (we_n),
    .bg                    (bg),
    .ba                    (ba),
    .addr                  (addr),
    .per_device_addressing (per_device_addressing),
    .pda_dq0               (pda_dq0),
    .cmd                   (cmd)
  );

  // Settling count depends on the size of the level step.
  function automatic logic [TMR_W-1:0] settle_cnt(input logic [LVL_W-1:0] a,
                                                  input logic [LVL_W-1:0] b);
    logic [LVL_W-1:0] d;
    d = (a > b) ? (a - b) : (b - a);
    return (d <= LVL_SHORT) ? TMR_W'(SETTLE_SHORT_CYC - 1) : TMR_W'(SETTLE_LONG_CYC - 1);
  endfunction

  assign mr6_hit  = cmd.mrs && cmd.qual_ok && (cmd.mr_sel == MR6_SEL);
  assign lvl_wr   = (st_q == ST_CAL) && mr6_hit && cmd.op[MR_EN_BIT];
  assign exit_cmd = (st_q == ST_CAL) && mr6_hit && !cmd.op[MR_EN_BIT];

  // ----------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_q        <= ST_OFF;
      phase_tmr_q <= '0;
    end else begin
      case (st_q)
        ST_OFF: begin
          if (mr6_hit && cmd.op[MR_EN_BIT]) begin
            st_q        <= ST_ENTRY; // R1
            phase_tmr_q <= TMR_W'(ENTRY_CYC - 1);
          end
        end
        ST_ENTRY: begin
          if (phase_tmr_q == '0) begin
            st_q <= ST_CAL; // R2
          end else begin
            phase_tmr_q <= phase_tmr_q - 1'b1;
          end
        end
        ST_CAL: begin
          if (exit_cmd) begin
            st_q        <= ST_EXIT;
            phase_tmr_q <= TMR_W'(EXIT_CYC - 1); // R11
          end
        end
        ST_EXIT: begin
          if (phase_tmr_q == '0) begin
            st_q <= ST_OFF;
          end else begin
            phase_tmr_q <= phase_tmr_q - 1'b1;
          end
        end
        default: begin
          st_q <= ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Range and level storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      range_q <= RANGE_ONE;
      level_q <= LVL_RST;
    end else if ((st_q == ST_OFF) && mr6_hit && cmd.op[MR_EN_BIT]) begin
      range_q <= cmd.op[MR_RNG_BIT]; // R1 R14 R16 R17
    end else if (lvl_wr) begin
      level_q <= cmd.op[LVL_W-1:0]; // R5 R9 R12 R13
    end
  end

  // ----------------------------------------------------------------
  // Settling, flags and bank tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      settle_tmr_q <= '0;
      valid_q      <= 1'b0;
    end else if (lvl_wr) begin
      settle_tmr_q <= settle_cnt(level_q, cmd.op[LVL_W-1:0]); // R7
      valid_q      <= 1'b0;
    end else if (settle_tmr_q != '0) begin
      settle_tmr_q <= settle_tmr_q - 1'b1;
    end else begin
      valid_q      <= first_done_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      first_done_q <= 1'b0;
      dummy_q      <= 1'b0;
      active_q     <= 1'b0;
    end else begin
      if (lvl_wr) begin
        first_done_q <= 1'b1;
      end
      dummy_q  <= (st_q == ST_CAL) && !first_done_q && !lvl_wr; // R4
      active_q <= (st_q == ST_OFF) ? (mr6_hit && cmd.op[MR_EN_BIT])
                                   : !((st_q == ST_EXIT) && (phase_tmr_q == '0)); // R17
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      open_q <= 16'h0000;
    end else if (cmd.act) begin
      open_q[cmd.bank] <= 1'b1;
    end else if (cmd.pre) begin
      if (cmd.auto_pre) begin
        open_q <= 16'h0000;
      end else begin
        open_q[cmd.bank] <= 1'b0;
      end
    end else if ((cmd.wr || cmd.rd) && cmd.auto_pre) begin
      open_q[cmd.bank] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Protocol violation detection
  // ----------------------------------------------------------------
  always_comb begin
    bad = 1'b0;
    case (st_q)
      ST_ENTRY: bad = !cmd.des; // R2
      ST_EXIT:  bad = !cmd.des; // R11
      ST_CAL: begin
        bad = cmd.other || (cmd.mrs && (cmd.mr_sel != MR6_SEL)); // R3
        if (pda_q && (cmd.act || cmd.wr || cmd.rd || cmd.pre)) begin
          bad = 1'b1; // R8
        end
        if (lvl_wr && ((cmd.op[MR_RNG_BIT] != range_q) || (cmd.op[LVL_W-1:0] > LVL_MAX))) begin
          bad = 1'b1; // R13
        end
        if (exit_cmd && ((open_q != 16'h0000) || (settle_tmr_q != '0) || !first_done_q)) begin
          bad = 1'b1; // R10 R12 R15
        end
      end
      default: bad = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      illegal_q <= 1'b0;
      pda_q     <= 1'b0;
    end else begin
      illegal_q <= bad;
      pda_q     <= per_device_addressing; // R8
    end
  end

  assign cal_active               = active_q;
  assign ref_range                = range_q;
  assign dq_input_reference_level = level_q;
  assign ref_valid                = valid_q;
  assign dummy_write_ok           = dummy_q;
  assign cmd_illegal              = illegal_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int A_ENTRY_MAX = 40;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_entry_latch_range: assert property ( // R1
    (st_q == ST_OFF) && mr6_hit && cmd.op[MR_EN_BIT]
      |=> (st_q == ST_ENTRY) && (range_q == $past(cmd.op[MR_RNG_BIT])))
    else $error("Entry did not latch range.");

  a_entry_no_level: assert property ( // R14
    (st_q == ST_OFF) && mr6_hit |=> $stable(level_q))
    else $error("Entry command changed the level.");

  a_off_write_blocked: assert property ( // R6
    (st_q == ST_OFF) && mr6_hit && !cmd.op[MR_EN_BIT] |=> $stable(range_q) && $stable(level_q))
    else $error("Disabled mode write changed fields.");

  a_entry_wait_ends: assert property ( // R2
    $rose(st_q == ST_ENTRY) |-> ##[1:A_ENTRY_MAX] (st_q == ST_CAL))
    else $error("Entry wait did not end.");

  a_level_store: assert property ( // R5
    lvl_wr |=> (level_q == $past(cmd.op[LVL_W-1:0])) && $stable(range_q) && !ref_valid)
    else $error("Level write mishandled.");

  a_exit_keeps_setting: assert property ( // R9
    exit_cmd |=> (st_q == ST_EXIT) && $stable(level_q) && $stable(range_q) ##1 $stable(level_q))
    else $error("Exit altered setting.");

  a_pda_only_mrs: assert property ( // R8
    (st_q == ST_CAL) && pda_q && cmd.act |=> cmd_illegal)
    else $error("Activate under per-device addressing not flagged.");

  a_exit_open_bank: assert property ( // R10
    exit_cmd && (open_q != 16'h0000) |=> cmd_illegal)
    else $error("Exit with open bank not flagged.");

  a_active_flag: assert property ( // R17
    (st_q == ST_CAL) |-> cal_active)
    else $error("Active flag low in calibration.");

  c_entry: cover property ((st_q == ST_OFF) ##1 (st_q == ST_ENTRY));
  c_level: cover property (lvl_wr);
  c_dummy: cover property (dummy_write_ok && cmd.wr);
  c_exit:  cover property ((st_q == ST_EXIT) ##1 (st_q == ST_OFF));

endmodule

// *** hdl/vrc_pkg.sv ***
// Constants and types for the data-input reference calibration block.
package vrc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int T_ENTRY_NS       = 150;
  localparam int T_EXIT_NS        = 150;
  localparam int T_SETTLE_SHORT_NS = 80;
  localparam int T_SETTLE_LONG_NS = 250;

  // Least times round up to whole cycles, never below one.
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ENTRY_CYC       = ceil_cyc(T_ENTRY_NS);
  localparam int EXIT_CYC        = ceil_cyc(T_EXIT_NS);
  localparam int SETTLE_SHORT_CYC = ceil_cyc(T_SETTLE_SHORT_NS);
  localparam int SETTLE_LONG_CYC = ceil_cyc(T_SETTLE_LONG_NS);
  localparam int TMR_W           = 8;

  // ----------------------------------------------------------------
  // Mode register 6 layout
  // ----------------------------------------------------------------
  localparam logic [2:0] MR6_SEL    = 3'h6;
  localparam int         MR_EN_BIT  = 7;
  localparam int         MR_RNG_BIT = 6;
  localparam int         LVL_W      = 6;
  localparam logic [5:0] LVL_MAX    = 6'h32;
  localparam logic [5:0] LVL_SHORT  = 6'h01;
  localparam logic       RANGE_ONE  = 1'h0;
  localparam logic [5:0] LVL_RST    = 6'h00;
  localparam int         ADDR_W     = 18;
  localparam int         AP_BIT     = 10;

  // ----------------------------------------------------------------
  // Mode states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,
    ST_ENTRY = 4'h2,
    ST_CAL   = 4'h4,
    ST_EXIT  = 4'h8
  } vrc_state_t;

endpackage

// *** hdl/vrc_cmd_if.sv ***
// Decoded command carrier between the decoder and the mode controller.
interface vrc_cmd_if;
  logic        act;
  logic        wr;
  logic        rd;
  logic        pre;
  logic        mrs;
  logic        des;
  logic        other;
  logic        auto_pre;
  logic        qual_ok;
  logic [3:0]  bank;
  logic [2:0]  mr_sel;
  logic [17:0] op;

  modport dec (output act, wr, rd, pre, mrs, des, other, auto_pre, qual_ok, bank, mr_sel, op);
  modport ctl (input  act, wr, rd, pre, mrs, des, other, auto_pre, qual_ok, bank, mr_sel, op);
endinterface

// *** hdl/vrc_cmd_dec.sv ***
// Command bus decoder that registers one decoded command per clock.
module vrc_cmd_dec
  import vrc_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic               cs_n,
  input  wire logic               act_n,
  input  wire logic               ras_n,
  input  wire logic               cas_n,
  input  wire logic               we_n,
  input  wire logic [1:0]         bg,
  input  wire logic [1:0]         ba,
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic               per_device_addressing,
  input  wire logic               pda_dq0,
  vrc_cmd_if.dec                  cmd
);
  import vrc_pkg::*;

  logic [2:0] rcw;
  assign rcw = {ras_n, cas_n, we_n};

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cmd.act      <= 1'b0;
      cmd.wr       <= 1'b0;
      cmd.rd       <= 1'b0;
      cmd.pre      <= 1'b0;
      cmd.mrs      <= 1'b0;
      cmd.des      <= 1'b1;
      cmd.other    <= 1'b0;
      cmd.auto_pre <= 1'b0;
      cmd.qual_ok  <= 1'b0;
      cmd.bank     <= 4'h0;
      cmd.mr_sel   <= 3'h0;
      cmd.op       <= 18'h00000;
    end else begin
      cmd.act      <= !cs_n && !act_n;
      cmd.wr       <= !cs_n && act_n && (rcw == 3'h4);
      cmd.rd       <= !cs_n && act_n && (rcw == 3'h5);
      cmd.pre      <= !cs_n && act_n && (rcw == 3'h2);
      cmd.mrs      <= !cs_n && act_n && (rcw == 3'h0);
      cmd.des      <= cs_n || (act_n && (rcw == 3'h7));
      cmd.other    <= !cs_n && act_n && (rcw inside {3'h1, 3'h3, 3'h6});
      cmd.auto_pre <= addr[AP_BIT];
      // With per-device addressing a mode write counts only when DQ0 is low.
      cmd.qual_ok  <= !per_device_addressing || !pda_dq0;
      cmd.bank     <= {bg, ba};
      cmd.mr_sel   <= {bg[0], ba};
      cmd.op       <= addr;
    end
  end

endmodule

// *** bench/vrc_host_model.sv ***
// Memory controller model that drives the command pins of the block.
module vrc_host_model
  import vrc_pkg::*;
(
  input  wire logic              core_clk,
  output logic                   cs_n,
  output logic                   act_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic [1:0]             bg,
  output logic [1:0]             ba,
  output logic [ADDR_W-1:0]      addr,
  output logic                   per_device_addressing,
  output logic                   pda_dq0
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Command tasks
  // ----------------------------------------------------------------
  initial begin
    {cs_n, act_n, ras_n, cas_n, we_n, bg, ba} = 9'h1FF;
    addr = '0;
    {per_device_addressing, pda_dq0} = 2'h0;
  end

  // Drives one command for one cycle; b is the bank or mode register number.
  task automatic drive(input logic [3:0] c, input logic [3:0] b, input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    cs_n <= 1'b0;
    {act_n, ras_n, cas_n, we_n} <= c;
    {bg, ba} <= b;
    addr <= a;
  endtask

  // Deselect cycles; the unselected lines show a changing pattern.
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      cs_n <= 1'b1;
      {bg, ba, addr} <= ~{bg, ba, addr};
    end
  endtask

  task automatic enter(input logic rng);
    drive(4'h8, {1'b0, MR6_SEL}, {10'h000, 1'b1, rng, 6'h00});
  endtask

  task automatic lvl(input logic rng, input logic [5:0] code);
    drive(4'h8, {1'b0, MR6_SEL}, {10'h000, 1'b1, rng, code});
  endtask

  task automatic exit_cal(input logic [6:0] junk);
    drive(4'h8, {1'b0, MR6_SEL}, {10'h000, 1'b0, junk});
  endtask

  task automatic set_pda(input logic on, input logic dq0);
    @(posedge core_clk);
    per_device_addressing <= on;
    pda_dq0 <= dq0;
  endtask
endmodule

// *** bench/dq_reference_calibration_mode_tb_top.sv ***
// Self-checking testbench for the reference calibration mode controller.
module dq_reference_calibration_mode_tb_top
  import vrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [3:0] C_ACT = 4'h7;
  localparam logic [3:0] C_WR  = 4'hC;
  localparam logic [3:0] C_RD  = 4'hD;
  localparam logic [3:0] C_PRE = 4'hA;
  localparam logic [3:0] C_REF = 4'h9;
  localparam logic [3:0] C_MRS = 4'h8;
  logic                  core_clk, nrst, cs_n, act_n, ras_n, cas_n, we_n;
  logic                  per_device_addressing, pda_dq0;
  logic [1:0]            bg, ba;
  logic [ADDR_W-1:0]     addr;
  logic                  cal_active, ref_range, ref_valid, dummy_write_ok, cmd_illegal;
  logic [LVL_W-1:0]      dq_input_reference_level;
  logic [15:0]           lfsr_q;
  logic                  exp_rng;
  logic [5:0]            exp_lvl, v;
  logic [ADDR_W-1:0]     ra;
  logic [3:0]            rb;
  int                    bad_count, num_checks, ill_cnt, ill0;

  vrc_host_model host (.core_clk(core_clk), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .addr(addr),
    .per_device_addressing(per_device_addressing), .pda_dq0(pda_dq0));

  vrc_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .addr(addr),
    .per_device_addressing(per_device_addressing), .pda_dq0(pda_dq0),
    .cal_active(cal_active), .ref_range(ref_range),
    .dq_input_reference_level(dq_input_reference_level), .ref_valid(ref_valid),
    .dummy_write_ok(dummy_write_ok), .cmd_illegal(cmd_illegal));

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (cmd_illegal === 1'b1) ill_cnt <= ill_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic next_rnd(output logic [5:0] r);
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    r = 6'(lfsr_q % 16'd51);
  endtask

  // Draws a random address and bank for commands whose fields do not matter.
  task automatic next_fields();
    next_rnd(v);
    ra = {lfsr_q[1:0], lfsr_q};
    rb = lfsr_q[9:6];
  endtask

  function automatic int settle_exp(input logic [5:0] o, input logic [5:0] n);
    int d;
    d = int'(o) - int'(n);
    if (d < 0) d = -d;
    return (d <= int'(LVL_SHORT)) ? SETTLE_SHORT_CYC : SETTLE_LONG_CYC;
  endfunction

  // Waits for ref_valid high (sel 0) or cal_active low (sel 1); three cycles already gone.
  task automatic wait_sig(input int sel, input int min_cyc, input string what);
    int n;
    n = 3;
    while (((sel == 0) ? ref_valid : !cal_active) !== 1'b1) begin
      host.idle(1);
      #1;
      n++;
      if (n > 400) begin
        bad_count++;
        $display("[ERR] %0t %s never came", $time, what);
        print_verdict();
      end
    end
    chk(8'(n >= min_cyc), 8'h01, what);
  endtask

  task automatic set_level(input logic [5:0] code, input logic rng, input int ill_exp);
    int s;
    s = settle_exp(exp_lvl, code);
    ill0 = ill_cnt;
    host.lvl(rng, code);
    host.idle(3);
    #1;
    chk(8'(dq_input_reference_level), 8'(code), "level");
    chk(8'(ref_valid), 8'h00, "valid while settling");
    exp_lvl = code;
    wait_sig(0, s, "settle");
    chk(8'(ill_cnt - ill0), 8'(ill_exp), "illegal count");
    chk(8'(ref_range), 8'(exp_rng), "range held");
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    lfsr_q = 16'h000F;
    {exp_rng, exp_lvl, v} = '0;
    {bad_count, num_checks, ill_cnt, ill0} = '0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    host.idle(2);
    #1;
    chk(8'({cal_active, ref_range, ref_valid, dummy_write_ok, cmd_illegal}), 8'h00, "reset");
    host.drive(C_MRS, {1'b0, MR6_SEL}, 18'h0007F);
    host.drive(C_MRS, 4'h5, 18'h000C0);
    host.idle(4);
    #1;
    chk(8'({cal_active, ref_range, dq_input_reference_level}), 8'h00, "no entry");
    $display("test idle done");
    exp_rng = 1'b1;
    host.enter(1'b1);
    host.idle(3);
    #1;
    chk(8'({cal_active, ref_range}), 8'h03, "entered");
    host.idle(ENTRY_CYC + 4);
    #1;
    chk(8'(dummy_write_ok), 8'h01, "dummy ok");
    ill0 = ill_cnt;
    next_fields();
    host.drive(C_WR, rb, ra);
    host.drive(C_RD, rb, ra);
    host.idle(4);
    #1;
    chk(8'(ill_cnt - ill0), 8'h00, "dummy traffic");
    set_level(LVL_MAX, exp_rng, 0);
    chk(8'(dummy_write_ok), 8'h00, "dummy closed");
    set_level(LVL_MAX - 6'h01, exp_rng, 0);
    for (int i = 0; i < 5; i++) begin
      next_fields();
      host.drive(C_ACT, 4'(i), ra);
      host.drive(C_WR, 4'(i), ra);
      host.drive(C_RD, 4'(i), ra);
      host.drive(C_PRE, rb, ra | 18'h00400);
      set_level(v, exp_rng, 0);
    end
    $display("test sweep done");
    set_level(6'h10, ~exp_rng, 1);
    ill0 = ill_cnt;
    host.lvl(exp_rng, 6'h33);
    next_fields();
    host.drive(C_REF, rb, ra);
    host.drive(C_MRS, 4'h5, ra);
    host.idle(4);
    #1;
    chk(8'(ill_cnt - ill0), 8'h03, "bad commands");
    exp_lvl = 6'h33;
    set_level(LVL_MAX, exp_rng, 0);
    host.set_pda(1'b1, 1'b0);
    ill0 = ill_cnt;
    host.drive(C_ACT, rb, ra);
    host.idle(4);
    #1;
    chk(8'(ill_cnt - ill0), 8'h01, "act with pda");
    host.set_pda(1'b1, 1'b1);
    host.lvl(exp_rng, 6'h05);
    host.idle(4);
    #1;
    chk(8'(dq_input_reference_level), 8'(exp_lvl), "pda ignored");
    host.set_pda(1'b1, 1'b0);
    set_level(6'h31, exp_rng, 0);
    host.set_pda(1'b0, 1'b0);
    host.drive(C_PRE, rb, ra | 18'h00400);
    $display("test faults done");
    next_rnd(v);
    set_level(v, exp_rng, 0);
    ill0 = ill_cnt;
    host.exit_cal(lfsr_q[6:0]);
    host.idle(3);
    #1;
    chk(8'({ref_range, dq_input_reference_level}), 8'({exp_rng, exp_lvl}), "kept");
    wait_sig(1, EXIT_CYC, "exit delay");
    chk(8'(ill_cnt - ill0), 8'h00, "clean exit");
    $display("test exit done");
    exp_rng = 1'b0;
    host.enter(1'b0);
    host.idle(3);
    ill0 = ill_cnt;
    next_fields();
    host.drive(C_WR, rb, ra);
    host.idle(ENTRY_CYC + 4);
    #1;
    chk(8'(ill_cnt - ill0), 8'h01, "early command");
    chk(8'({cal_active, ref_range}), 8'h02, "range one");
    host.drive(C_ACT, rb, ra);
    set_level(6'h20, exp_rng, 0);
    ill0 = ill_cnt;
    host.exit_cal(7'h7F);
    host.idle(3);
    host.drive(C_REF, rb, ra);
    host.idle(1);
    #1;
    wait_sig(1, EXIT_CYC - 2, "exit delay");
    chk(8'(ill_cnt - ill0), 8'h02, "open bank exit");
    chk(8'({ref_range, dq_input_reference_level}), 8'h20, "kept");
    $display("test second entry done");
    print_verdict();
  end
endmodule
